// ===== quad_adc_regs_pkg.sv
// Purpose: Shared constants for the four-channel converter control register bank
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   Field positions and reset values are named once here
package quad_adc_regs_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h05;
	localparam logic [7:0] ADDR_POWER_MODE     = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_DIVIDER  = 8'h0B;
	localparam logic [7:0] ADDR_SHUFFLE        = 8'h0C;
	localparam logic [7:0] ADDR_TEST_PATTERN   = 8'h0D;
	localparam logic [7:0] ADDR_SHADOW_UPDATE  = 8'hFF;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_CHANNEL_SELECT = 8'hCF;
	localparam logic [7:0] RST_POWER_MODE     = 8'h00;
	localparam logic [7:0] RST_CLOCK_DIVIDER  = 8'h00;
	localparam logic [7:0] RST_SHUFFLE        = 8'h01;
	localparam logic [7:0] RST_TEST_PATTERN   = 8'h00;
	localparam logic [7:0] RST_SHADOW_UPDATE  = 8'h00;

	// ****************************************
	// Writable bit masks (open bits read zero)
	// ****************************************
	localparam logic [7:0] MASK_CHANNEL_SELECT = 8'hCF;
	localparam logic [7:0] MASK_POWER_MODE     = 8'h23;
	localparam logic [7:0] MASK_CLOCK_DIVIDER  = 8'h3F;
	localparam logic [7:0] MASK_SHUFFLE        = 8'h01;
	localparam logic [7:0] MASK_TEST_PATTERN   = 8'h37;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int POS_TRANSFER_BIT   = 0;
	localparam int POS_SHUFFLE_BIT    = 0;
	localparam int POS_LONG_PN_RESET  = 5;
	localparam int POS_SHORT_PN_RESET = 4;
	localparam int POS_EXT_PD_FUNC    = 5;
	localparam logic [7:0] TRANSFER_COMMAND = 8'h01;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [2:0] {
		TEST_OFF      = 3'b000,
		TEST_MIDSCALE = 3'b001,
		TEST_POS_FS   = 3'b010,
		TEST_NEG_FS   = 3'b011,
		TEST_CHECKER  = 3'b100,
		TEST_PN_LONG  = 3'b101,
		TEST_PN_SHORT = 3'b110,
		TEST_TOGGLE   = 3'b111
	} test_mode_t;

	typedef enum logic [1:0] {
		PWR_NORMAL  = 2'b00,
		PWR_FULL_PD = 2'b01,
		PWR_STANDBY = 2'b10,
		PWR_RSVD    = 2'b11
	} power_mode_t;

	// PN generator seeds (arbitrary choices; maximal-length taps live in the pattern module)
	localparam logic [22:0] PN_LONG_SEED  = 23'h7FFFFF;
	localparam logic [8:0]  PN_SHORT_SEED = 9'h1FF;

endpackage

// ===== quad_adc_channel_pattern.sv
// Purpose: Per-channel output word selection between samples and test data
// Assumes: One sample per SAMPLE_EN pulse
// Notes:   Output word registered; PN generators per channel, held at seed until their run bits are set
`timescale 1ns/1ns
module quad_adc_channel_pattern #(
	parameter int WIDTH = 11
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             sample_en,
	input  wire logic [2:0]       mode,
	input  wire logic             long_pn_hold,
	input  wire logic             short_pn_hold,
	input  wire logic [WIDTH-1:0] sample,
	output logic [WIDTH-1:0]      word
);

	// Short pattern borrows long bits above bit 8, so at least 10 bits
	if (WIDTH < 10 || WIDTH > 23) begin : gen_width_check
		$error("WIDTH out of range");
	end

	logic [22:0] pn_long;
	logic [8:0]  pn_short;
	logic        toggle;
	logic [WIDTH-1:0] next_word;

	// ****************************************
	// Pattern generators
	// ****************************************
	// Generators held at seed while their reset bit is cleared
	always_ff @(posedge clk) begin
		if (rst || long_pn_hold) begin
			pn_long <= quad_adc_regs_pkg::PN_LONG_SEED;
		end else if (sample_en) begin
			pn_long <= {pn_long[21:0], pn_long[22] ^ pn_long[17]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || short_pn_hold) begin
			pn_short <= quad_adc_regs_pkg::PN_SHORT_SEED;
		end else if (sample_en) begin
			pn_short <= {pn_short[7:0], pn_short[8] ^ pn_short[4]};
		end
	end

	// Toggles every sample for checkerboard and word toggle
	always_ff @(posedge clk) begin
		if (rst) begin
			toggle <= 1'b0;
		end else if (sample_en) begin
			toggle <= ~toggle;
		end
	end

	// ****************************************
	// Word selection
	// ****************************************
	always_comb begin
		case (quad_adc_regs_pkg::test_mode_t'(mode))
			quad_adc_regs_pkg::TEST_OFF:      next_word = sample;
			quad_adc_regs_pkg::TEST_MIDSCALE: next_word = {1'b1, {(WIDTH-1){1'b0}}};
			quad_adc_regs_pkg::TEST_POS_FS:   next_word = {WIDTH{1'b1}};
			quad_adc_regs_pkg::TEST_NEG_FS:   next_word = {WIDTH{1'b0}};
			quad_adc_regs_pkg::TEST_CHECKER:
				next_word = toggle ? WIDTH'({(WIDTH+1)/2{2'b10}}) : WIDTH'({(WIDTH+1)/2{2'b01}});
			quad_adc_regs_pkg::TEST_PN_LONG:  next_word = pn_long[WIDTH-1:0];
			quad_adc_regs_pkg::TEST_PN_SHORT:
				next_word = WIDTH'({pn_long[WIDTH-1:9], pn_short});
			quad_adc_regs_pkg::TEST_TOGGLE:   next_word = {WIDTH{toggle}};
			default:                          next_word = sample;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word <= '0;
		end else if (sample_en) begin
			word <= next_word;
		end
	end

endmodule

// ===== quad_adc_control_register_bank.sv
// Purpose: Serial-port register bank for a four-channel converter receiver
// Assumes: 8-bit write/read port from a serial-port front end, single clock
// Notes:   Function registers shadowed until a transfer command
//
// Overview of operation
// - Test code zero passes normal samples
// - Codes 1-3 give midscale, +FS, -FS
// - Code 4 gives checkerboard pattern
// - Code 5 gives long PN sequence
// - Code 6 gives short PN sequence
// - Code 7 toggles all-ones and all-zeros
// - Power-down field resets to normal
// - 01 full power-down, 10 standby
// - Shadow values apply on transfer write
// - Transfer bit clears itself after apply
// - Local writes go to selected channels
// - Multi-select reads return lowest selected channel
`timescale 1ns/1ns
module quad_adc_control_register_bank #(
	parameter int WIDTH = 11
) (
	input  wire logic               MCLK,
	input  wire logic               RST,
	input  wire logic               WR_EN,
	input  wire logic               RD_EN,
	input  wire logic [7:0]         ADDR,
	input  wire logic [7:0]         WDATA,
	output logic [7:0]              RDATA,
	input  wire logic [4*WIDTH-1:0] SAMPLES,
	output logic [4*WIDTH-1:0]      DATA_OUT,
	output logic [7:0]              PWR_MODES,
	output logic                    EXT_PD_STANDBY,
	output logic [3:0]              SHUFFLE_EN,
	output logic [1:0]              PORT_ENABLE,
	output logic                    SAMPLE_EN,
	output logic [2:0]              CLK_PHASE
);

	localparam int CH = 4;

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] channel_select;
	logic [7:0] shadow_update;
	logic [7:0] pend_power [CH];
	logic [7:0] pend_shuffle [CH];
	logic [7:0] pend_test [CH];
	logic [7:0] pend_clock;
	logic [7:0] live_power [CH];
	logic [7:0] live_shuffle [CH];
	logic [7:0] live_test [CH];
	logic [7:0] live_clock;
	logic [2:0] div_count;
	logic [7:0] next_rdata;
	logic       transfer_req;

	// First selected channel, lowest-numbered channel wins when several set
	function automatic int first_channel(input logic [3:0] sel);
		first_channel = 0;
		for (int i = CH - 1; i >= 0; i--) begin
			if (sel[i]) begin
				first_channel = i;
			end
		end
	endfunction

	assign transfer_req = WR_EN && ADDR == quad_adc_regs_pkg::ADDR_SHADOW_UPDATE
		&& WDATA[quad_adc_regs_pkg::POS_TRANSFER_BIT];

	// Channel index is not shadowed
	always_ff @(posedge MCLK) begin
		if (RST) begin
			channel_select <= quad_adc_regs_pkg::RST_CHANNEL_SELECT;
		end else if (WR_EN && ADDR == quad_adc_regs_pkg::ADDR_CHANNEL_SELECT) begin
			channel_select <= WDATA & quad_adc_regs_pkg::MASK_CHANNEL_SELECT;
		end
	end

	// Transfer bit set by command, cleared on the same edge that applies it
	always_ff @(posedge MCLK) begin
		if (RST) begin
			shadow_update <= quad_adc_regs_pkg::RST_SHADOW_UPDATE;
		end else if (transfer_req) begin
			shadow_update <= quad_adc_regs_pkg::TRANSFER_COMMAND;
		end else begin
			shadow_update <= quad_adc_regs_pkg::RST_SHADOW_UPDATE;
		end
	end

	// ****************************************
	// Pending (master) registers
	// ****************************************
	// Global clock divider pending copy ignores channel select
	always_ff @(posedge MCLK) begin
		if (RST) begin
			pend_clock <= quad_adc_regs_pkg::RST_CLOCK_DIVIDER;
		end else if (WR_EN && ADDR == quad_adc_regs_pkg::ADDR_CLOCK_DIVIDER) begin
			pend_clock <= WDATA & quad_adc_regs_pkg::MASK_CLOCK_DIVIDER;
		end
	end

	// Local pending copies written for every selected channel
	always_ff @(posedge MCLK) begin
		if (RST) begin
			for (int c = 0; c < CH; c++) begin
				pend_power[c]   <= quad_adc_regs_pkg::RST_POWER_MODE;
				pend_shuffle[c] <= quad_adc_regs_pkg::RST_SHUFFLE;
				pend_test[c]    <= quad_adc_regs_pkg::RST_TEST_PATTERN;
			end
		end else if (WR_EN) begin
			for (int c = 0; c < CH; c++) begin
				// External pin function is global, so every copy follows it
				if (ADDR == quad_adc_regs_pkg::ADDR_POWER_MODE) begin
					pend_power[c][quad_adc_regs_pkg::POS_EXT_PD_FUNC] <=
						WDATA[quad_adc_regs_pkg::POS_EXT_PD_FUNC];
				end
				if (channel_select[c]) begin
					if (ADDR == quad_adc_regs_pkg::ADDR_POWER_MODE) begin
						pend_power[c][1:0] <= WDATA[1:0];
					end
					if (ADDR == quad_adc_regs_pkg::ADDR_SHUFFLE) begin
						pend_shuffle[c] <= WDATA & quad_adc_regs_pkg::MASK_SHUFFLE;
					end
					if (ADDR == quad_adc_regs_pkg::ADDR_TEST_PATTERN) begin
						pend_test[c] <= WDATA & quad_adc_regs_pkg::MASK_TEST_PATTERN;
					end
				end
			end
		end
	end

	// ****************************************
	// Live (slave) registers
	// ****************************************
	// All pending values move together on the transfer command
	always_ff @(posedge MCLK) begin
		if (RST) begin
			live_clock <= quad_adc_regs_pkg::RST_CLOCK_DIVIDER;
			for (int c = 0; c < CH; c++) begin
				live_power[c]   <= quad_adc_regs_pkg::RST_POWER_MODE;
				live_shuffle[c] <= quad_adc_regs_pkg::RST_SHUFFLE;
				live_test[c]    <= quad_adc_regs_pkg::RST_TEST_PATTERN;
			end
		end else if (shadow_update[quad_adc_regs_pkg::POS_TRANSFER_BIT]) begin
			live_clock <= pend_clock;
			for (int c = 0; c < CH; c++) begin
				live_power[c]   <= pend_power[c];
				live_shuffle[c] <= pend_shuffle[c];
				live_test[c]    <= pend_test[c];
			end
		end
	end

	// ****************************************
	// Clock divider
	// ****************************************
	// Count wraps at ratio field, one enable pulse per divided cycle
	always_ff @(posedge MCLK) begin
		if (RST) begin
			div_count <= '0;
		end else if (div_count >= live_clock[2:0]) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + 3'h1;
		end
	end

	assign SAMPLE_EN = div_count >= live_clock[2:0];
	assign CLK_PHASE = live_clock[5:3];

	// ****************************************
	// Readback
	// ****************************************
	always_comb begin
		int f;
		f = first_channel(channel_select[3:0]);
		case (ADDR)
			quad_adc_regs_pkg::ADDR_CHANNEL_SELECT: next_rdata = channel_select;
			quad_adc_regs_pkg::ADDR_SHADOW_UPDATE:  next_rdata = shadow_update;
			quad_adc_regs_pkg::ADDR_CLOCK_DIVIDER:  next_rdata = pend_clock;
			quad_adc_regs_pkg::ADDR_POWER_MODE:     next_rdata = pend_power[f];
			quad_adc_regs_pkg::ADDR_SHUFFLE:        next_rdata = pend_shuffle[f];
			quad_adc_regs_pkg::ADDR_TEST_PATTERN:   next_rdata = pend_test[f];
			default:                                next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD_EN) begin
			RDATA <= next_rdata;
		end
	end

	// ****************************************
	// Per-channel outputs
	// ****************************************
	// Power field decoded downstream: 00 normal, 01 full down, 10 standby
	always_ff @(posedge MCLK) begin
		if (RST) begin
			PWR_MODES      <= '0;
			SHUFFLE_EN     <= 4'hF;
			EXT_PD_STANDBY <= 1'b0;
			PORT_ENABLE    <= 2'h3;
		end else begin
			for (int c = 0; c < CH; c++) begin
				PWR_MODES[2*c +: 2] <= live_power[c][1:0];
				SHUFFLE_EN[c] <= live_shuffle[c][quad_adc_regs_pkg::POS_SHUFFLE_BIT];
			end
			EXT_PD_STANDBY <= live_power[0][quad_adc_regs_pkg::POS_EXT_PD_FUNC];
			PORT_ENABLE    <= channel_select[7:6];
		end
	end

	for (genvar g = 0; g < CH; g++) begin : gen_ch
		quad_adc_channel_pattern #(
			.WIDTH(WIDTH)
		) u_pattern (
			.clk           (MCLK),
			.rst           (RST),
			.sample_en     (SAMPLE_EN),
			.mode          (live_test[g][2:0]),
			.long_pn_hold  (~live_test[g][quad_adc_regs_pkg::POS_LONG_PN_RESET]),
			.short_pn_hold (~live_test[g][quad_adc_regs_pkg::POS_SHORT_PN_RESET]),
			.sample        (SAMPLES[g*WIDTH +: WIDTH]),
			.word          (DATA_OUT[g*WIDTH +: WIDTH])
		);
	end

endmodule

// ===== quad_adc_control_register_bank_props.sv
// Purpose: Port-level checks for the converter control register bank
// Assumes: Transfer write reaches live state two edges later
// Notes:   Registered outputs allowed two or three cycles after transfer
`timescale 1ns/1ns
module quad_adc_control_register_bank_props #(
	parameter int WIDTH = 11
) (
	input wire logic               MCLK,
	input wire logic               RST,
	input wire logic               WR_EN,
	input wire logic               RD_EN,
	input wire logic [7:0]         ADDR,
	input wire logic [7:0]         WDATA,
	input wire logic [7:0]         RDATA,
	input wire logic [4*WIDTH-1:0] SAMPLES,
	input wire logic [4*WIDTH-1:0] DATA_OUT,
	input wire logic [7:0]         PWR_MODES,
	input wire logic               EXT_PD_STANDBY,
	input wire logic [3:0]         SHUFFLE_EN,
	input wire logic [1:0]         PORT_ENABLE,
	input wire logic               SAMPLE_EN,
	input wire logic [2:0]         CLK_PHASE
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	logic xfer;
	// Transfer command seen at the port
	assign xfer = WR_EN && ADDR == 8'hFF && WDATA[0];
	reset_outs_a: assert property ($fell(RST)
		|-> PWR_MODES == 8'h00 && SHUFFLE_EN == 4'hF)
		else $error("outputs not at reset values");
	reset_div_a: assert property ($fell(RST) |-> SAMPLE_EN && RDATA == 8'h00)
		else $error("divider or read data not reset");
	pwr_shadow_a: assert property (!$stable(PWR_MODES) && !$past(RST)
		|-> $past(xfer, 2) || $past(xfer, 3))
		else $error("power modes moved without transfer");
	stby_shadow_a: assert property (!$stable(EXT_PD_STANDBY) && !$past(RST)
		|-> $past(xfer, 2) || $past(xfer, 3))
		else $error("standby function moved without transfer");
	shuf_shadow_a: assert property (!$stable(SHUFFLE_EN) && !$past(RST)
		|-> $past(xfer, 2) || $past(xfer, 3))
		else $error("shuffle enable moved without transfer");
	phase_shadow_a: assert property (!$stable(CLK_PHASE) && !$past(RST)
		|-> $past(xfer) || $past(xfer, 2))
		else $error("clock phase moved without transfer");
	data_on_sample_a: assert property (!$stable(DATA_OUT) && !$past(RST)
		|-> $past(SAMPLE_EN))
		else $error("output word changed off sample strobe");
	rdata_hold_a: assert property (!$past(RD_EN) && !$past(RST) |-> $stable(RDATA))
		else $error("read data changed without read");
	// Bit reads one only when the transfer came the cycle before the read
	xfer_clear_a: assert property (RD_EN && ADDR == 8'hFF
		|=> RDATA == {7'h00, $past(xfer, 2)})
		else $error("transfer bit not cleared");
	cover property (xfer);
	cover property (RD_EN && ADDR == 8'h08);
	cover property ($rose(SAMPLE_EN));
endmodule
bind quad_adc_control_register_bank quad_adc_control_register_bank_props #(.WIDTH(WIDTH)) i_props (
	.MCLK(MCLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
	.RDATA(RDATA), .SAMPLES(SAMPLES), .DATA_OUT(DATA_OUT), .PWR_MODES(PWR_MODES),
	.EXT_PD_STANDBY(EXT_PD_STANDBY), .SHUFFLE_EN(SHUFFLE_EN), .PORT_ENABLE(PORT_ENABLE),
	.SAMPLE_EN(SAMPLE_EN), .CLK_PHASE(CLK_PHASE));

// ===== quad_adc_host_model.sv
// Purpose: Serial-port host issuing register writes and reads
// Assumes: One strobe cycle per access, driven 2 ns after the edge
// Notes:   Address and data inverted when idle so stale values never match
`timescale 1ns/1ns
module quad_adc_host_model (
	input  wire logic       MCLK,
	input  wire logic [7:0] RDATA,
	output logic            WR_EN,
	output logic            RD_EN,
	output logic [7:0]      ADDR,
	output logic [7:0]      WDATA
);
	initial begin
		WR_EN = 0;
		RD_EN = 0;
		ADDR = 8'h00;
		WDATA = 8'h00;
	end
	// Single write; caller commits with 0x01 at 0xFF
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		#2 {WR_EN, ADDR, WDATA} = {1'b1, a, d};
		@(posedge MCLK);
		#2 {WR_EN, ADDR, WDATA} = {1'b0, ~a, ~d};
	endtask
	// Read data taken after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge MCLK);
		#2 {RD_EN, ADDR} = {1'b1, a};
		@(posedge MCLK);
		#2 {RD_EN, ADDR} = {1'b0, ~a};
		d = RDATA;
	endtask
endmodule

// ===== quad_adc_control_register_bank_bench.sv
// Purpose: Self-checking bench for the converter register bank
// Assumes: Divide by 1 except in the divider test
// Notes:   Expectations from the register table only
`timescale 1ns/1ns
module quad_adc_control_register_bank_bench;
	logic        MCLK;
	logic        RST = 1;
	logic [43:0] SAMPLES = 44'h123_4567_89AB;
	logic [7:0]  ADDR, WDATA, RDATA, PWR_MODES;
	logic        WR_EN, RD_EN, EXT_PD_STANDBY, SAMPLE_EN;
	logic [43:0] DATA_OUT;
	logic [3:0]  SHUFFLE_EN;
	logic [1:0]  PORT_ENABLE;
	logic [2:0]  CLK_PHASE;
	int          miscompares = 0;
	int          checked = 0;
	int          cyc = 0;
	quad_adc_host_model i_quad_adc_host_model (.MCLK(MCLK), .RDATA(RDATA), .WR_EN(WR_EN),
		.RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA));
	quad_adc_control_register_bank #(.WIDTH(11)) i_quad_adc_control_register_bank (
		.MCLK(MCLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
		.RDATA(RDATA), .SAMPLES(SAMPLES), .DATA_OUT(DATA_OUT), .PWR_MODES(PWR_MODES),
		.EXT_PD_STANDBY(EXT_PD_STANDBY), .SHUFFLE_EN(SHUFFLE_EN), .PORT_ENABLE(PORT_ENABLE),
		.SAMPLE_EN(SAMPLE_EN), .CLK_PHASE(CLK_PHASE));
	// ****
	// Helpers
	// ****
	task automatic cmp(input string n, input logic [43:0] s, input logic [43:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_quad_adc_host_model.rd(a, d);
		cmp("rdata", 44'(d), 44'(e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_quad_adc_host_model.wr(a, d);
	endtask
	// Commit pending values, then let outputs settle
	task automatic xfer;
		wr(8'hFF, 8'h01);
		repeat (4) @(posedge MCLK);
		#2;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		rd(8'h05, 8'hCF);
		rd(8'h08, 8'h00);
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h01);
		rd(8'h0D, 8'h00);
		rd(8'h01, 8'h00);
		cmp("pwr", 44'(PWR_MODES), 44'h0);
		cmp("port", 44'(PORT_ENABLE), 44'h3);
	endtask
	task automatic t_power;
		wr(8'h05, 8'h01);
		wr(8'h08, 8'h01);
		repeat (4) @(posedge MCLK);
		#2;
		cmp("pwr_pending", 44'(PWR_MODES), 44'h0);
		wr(8'hFF, 8'h01);
		rd(8'hFF, 8'h00);
		repeat (3) @(posedge MCLK);
		#2;
		cmp("pwr_down", 44'(PWR_MODES), 44'h01);
		wr(8'h05, 8'h0C);
		wr(8'h08, 8'h22);
		xfer();
		cmp("pwr_stby", 44'(PWR_MODES), 44'hA1);
		cmp("ext_pd", 44'(EXT_PD_STANDBY), 44'h1);
		wr(8'h05, 8'h0F);
		rd(8'h08, 8'h21);
	endtask
	task automatic t_shuffle;
		wr(8'h05, 8'h02);
		wr(8'h0C, 8'h00);
		xfer();
		cmp("shuffle", 44'(SHUFFLE_EN), 44'hD);
		cmp("port_off", 44'(PORT_ENABLE), 44'h0);
	endtask
	task automatic t_clkdiv;
		int n;
		n = 0;
		wr(8'h0B, 8'h1B);
		xfer();
		cmp("phase", 44'(CLK_PHASE), 44'h3);
		repeat (16) begin
			@(posedge MCLK);
			#2;
			n += (SAMPLE_EN === 1'b1);
		end
		cmp("div4", 44'(n), 44'd4);
		wr(8'h0B, 8'h00);
		xfer();
	endtask
	// Each test code on all channels; PN generators released to run
	task automatic t_patterns;
		logic [10:0] w0, w1;
		wr(8'h05, 8'h0F);
		for (int m = 0; m < 8; m++) begin
			wr(8'h0D, 8'h30 | 8'(m));
			xfer();
			w0 = DATA_OUT[10:0];
			@(posedge MCLK);
			#2;
			w1 = DATA_OUT[10:0];
			case (m)
				0: cmp("normal", DATA_OUT, SAMPLES);
				1: cmp("midscale", DATA_OUT, {4{11'h400}});
				2: cmp("pos_fs", DATA_OUT, {4{11'h7FF}});
				3: cmp("neg_fs", DATA_OUT, {4{11'h000}});
				4: cmp("checker", 44'(w1 == ~w0 && (w0 == 11'h555 || w0 == 11'h2AA)), 44'h1);
				5: cmp("pn_long", 44'(w0 !== w1 && w1[10:1] == w0[9:0]), 44'h1);
				6: cmp("pn_short", 44'(w0 !== w1 && w1[8:1] == w0[7:0]), 44'h1);
				7: cmp("toggle", 44'(w1 == ~w0 && (w0 == 11'h7FF || w0 == 11'h0)), 44'h1);
			endcase
		end
		// Run bits cleared: long generator parked at its all-ones seed
		wr(8'h0D, 8'h05);
		xfer();
		cmp("pn_hold", DATA_OUT, {4{11'h7FF}});
	endtask
	initial begin
		MCLK = 0;
		forever #10 MCLK = ~MCLK;
	end
	// Hang guard well above the expected run length
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (3) @(posedge MCLK);
		#2 RST = 0;
		t_reset();
		t_power();
		t_shuffle();
		t_clkdiv();
		t_patterns();
		end_sim();
	end
endmodule
